//--- src/dpm_host.sv
// Behaviour
// - Write ends on rising read/write select
// - Read waits out cross-port flowthrough delay
// - Read asserts output enable with select
// - Token read uses token select, output enable
// - Hold writes until busy input settles
// - Take token: write zero, read back, poll
// - Token gap and write-to-read delay respected
`timescale 1ns/1ps
`include "dpm_params.svh"

module dpm_host
  import dpm_pkg::*;
#(
  parameter int AW             = `DPM_ADDR_W,
  parameter int DW             = `DPM_DATA_W,
  parameter int POLLS          = `DPM_TAKE_POLLS,
  parameter int SEL_ACCESS_NS  = `DPM_SELECT_ACCESS_NS,
  parameter int DRV_ACCESS_NS  = `DPM_DRIVE_ACCESS_NS,
  parameter int WR_SETUP_NS    = `DPM_WRITE_DATA_SETUP_NS,
  parameter int FLOW_NS        = `DPM_FLOWTHROUGH_NS,
  parameter int BUSY_SETTLE_NS = `DPM_BUSY_SETTLE_NS,
  parameter int TOK_GAP_NS     = `DPM_TOKEN_OP_GAP_NS,
  parameter int TOK_WR_RD_NS   = `DPM_TOKEN_WR_RD_NS
) (
  input  wire logic          clk,
  input  wire logic          srst,
  input  wire logic          clk_en,
  input  wire logic          req_valid,
  output logic               req_ready,
  input  wire dpm_op_type    req_op,
  input  wire logic [AW-1:0] req_addr,
  input  wire logic [DW-1:0] req_wdata,
  output logic               rsp_valid,
  output logic [DW-1:0]      rsp_rdata,
  output logic               rsp_busy,
  output logic               mailbox_pending,
  output logic               mem_select_n,
  output logic               token_latch_select_n,
  output logic               read_write_n,
  output logic               output_enable_n,
  output logic [AW-1:0]      mem_addr,
  output logic [DW-1:0]      data_out,
  output logic               data_oe,
  input  wire logic [DW-1:0] data_in,
  input  wire logic          busy_n,
  input  wire logic          int_n
);

  localparam int TW = `DPM_TIMER_W;

  // ------------------------------------------------------------------------
  // Cycle counts derived from the port timing
  // ------------------------------------------------------------------------
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + `DPM_CLK_PERIOD_NS - 1) / `DPM_CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int imax(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  // Read wait also covers a write in flight on the other port
  localparam int RD_CYC     = imax(imax(cyc_up(SEL_ACCESS_NS), cyc_up(DRV_ACCESS_NS)), cyc_up(FLOW_NS));
  localparam int SRD_CYC    = cyc_up(DRV_ACCESS_NS);
  localparam int WR_CYC     = cyc_up(WR_SETUP_NS);
  localparam int SETTLE_CYC = cyc_up(BUSY_SETTLE_NS);
  localparam int GAP_CYC    = imax(cyc_up(TOK_GAP_NS), cyc_up(TOK_WR_RD_NS));

  function automatic logic is_token(input dpm_op_type op);
    return (op == DPM_OP_SEM_RD) || (op == DPM_OP_SEM_WR) || (op == DPM_OP_SEM_TAKE);
  endfunction

  // ------------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------------
  typedef struct packed {
    dpm_state_type st;
    dpm_op_type    op;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;
    logic          ce_n;
    logic          sem_n;
    logic          rw_n;
    logic          oe_n;
    logic          data_oe;
    logic          rsp_valid;
    logic          busy_seen;
    logic          irq;
    logic [7:0]    polls;
  } dpm_host_state_type;

  localparam dpm_host_state_type ST_RESET = '{
    st: DPM_ST_IDLE, op: DPM_OP_MEM_RD, addr: '0, wdata: '0, rdata: '0,
    ce_n: '1, sem_n: '1, rw_n: '1, oe_n: '1, data_oe: '0,
    rsp_valid: '0, busy_seen: '0, irq: '0, polls: '0
  };

  dpm_host_state_type st_ff;
  dpm_host_state_type nxt_st;
  logic               tmr_load;
  logic [TW-1:0]      tmr_val;
  logic               tmr_done;
  logic               repoll;

  dpm_tmr #(
    .W (TW)
  ) u_tmr (
    .clk      (clk),
    .srst     (srst),
    .clk_en   (clk_en),
    .load     (tmr_load),
    .load_val (tmr_val),
    .done     (tmr_done)
  );

  // ------------------------------------------------------------------------
  // Pin sequencer
  // ------------------------------------------------------------------------
  always_comb begin
    nxt_st           = st_ff;
    nxt_st.rsp_valid = 1'b0;
    nxt_st.irq       = ~int_n;
    tmr_load         = 1'b0;
    tmr_val          = '0;
    repoll           = (st_ff.op == DPM_OP_SEM_TAKE) && !st_ff.data_oe &&
                       st_ff.rdata[`DPM_TOKEN_BIT] && (st_ff.polls != '0);
    case (st_ff.st)
      DPM_ST_IDLE: begin
        if (req_valid) begin
          nxt_st.op        = req_op;
          nxt_st.wdata     = req_wdata;
          nxt_st.busy_seen = 1'b0;
          nxt_st.polls     = 8'(POLLS);
          tmr_load         = 1'b1;
          nxt_st.addr      = req_addr;
          if (is_token(req_op)) begin
            // Only the latch index is driven; upper lines are parked low
            nxt_st.addr  = {{(AW-`DPM_TOKEN_ADDR_W){1'b0}}, req_addr[`DPM_TOKEN_ADDR_W-1:0]};
            nxt_st.sem_n = 1'b0;
            nxt_st.st    = DPM_ST_ACC;
            if (req_op == DPM_OP_SEM_RD) begin
              nxt_st.oe_n = 1'b0;
              tmr_val     = TW'(SRD_CYC);
            end else begin
              nxt_st.rw_n    = 1'b0;
              nxt_st.data_oe = 1'b1;
              tmr_val        = TW'(WR_CYC);
              if (req_op == DPM_OP_SEM_TAKE) begin
                nxt_st.wdata = '0;
              end
            end
          end else begin
            nxt_st.ce_n = 1'b0;
            tmr_val     = TW'(SETTLE_CYC);
            nxt_st.st   = DPM_ST_ARB;
          end
        end
      end
      DPM_ST_ARB: begin
        // A lost contention would drop a write or a mailbox clear, so wait
        if (tmr_done) begin
          if (!busy_n) begin
            nxt_st.busy_seen = 1'b1;
          end else begin
            tmr_load  = 1'b1;
            nxt_st.st = DPM_ST_ACC;
            if (st_ff.op == DPM_OP_MEM_WR) begin
              nxt_st.rw_n    = 1'b0;
              nxt_st.data_oe = 1'b1;
              tmr_val        = TW'(WR_CYC);
            end else begin
              nxt_st.oe_n = 1'b0;
              tmr_val     = TW'(RD_CYC);
            end
          end
        end
      end
      DPM_ST_ACC: begin
        if (tmr_done) begin
          nxt_st.st = DPM_ST_REL;
          if (!st_ff.oe_n) begin
            nxt_st.rdata = data_in;
            nxt_st.oe_n  = 1'b1;
          end else begin
            nxt_st.rw_n = 1'b1;
          end
        end
      end
      DPM_ST_REL: begin
        // Data is still driven here, giving hold after the terminating edge
        nxt_st.ce_n    = 1'b1;
        nxt_st.sem_n   = 1'b1;
        nxt_st.data_oe = 1'b0;
        if ((is_token(st_ff.op) && st_ff.data_oe) || repoll) begin
          tmr_load  = 1'b1;
          tmr_val   = TW'(GAP_CYC);
          nxt_st.st = DPM_ST_GAP;
          if (repoll) begin
            nxt_st.polls = st_ff.polls - 8'h01;
          end
        end else begin
          nxt_st.rsp_valid = 1'b1;
          nxt_st.st        = DPM_ST_IDLE;
        end
      end
      DPM_ST_GAP: begin
        if (tmr_done) begin
          if (st_ff.op == DPM_OP_SEM_TAKE) begin
            nxt_st.sem_n = 1'b0;
            nxt_st.oe_n  = 1'b0;
            tmr_load     = 1'b1;
            tmr_val      = TW'(SRD_CYC);
            nxt_st.st    = DPM_ST_ACC;
          end else begin
            nxt_st.rsp_valid = 1'b1;
            nxt_st.st        = DPM_ST_IDLE;
          end
        end
      end
      default: begin
        nxt_st = ST_RESET;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_ff <= ST_RESET;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  // ------------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------------
  assign req_ready            = (st_ff.st == DPM_ST_IDLE);
  assign rsp_valid            = st_ff.rsp_valid;
  assign rsp_rdata            = st_ff.rdata;
  assign rsp_busy             = st_ff.busy_seen;
  assign mailbox_pending      = st_ff.irq;
  assign mem_select_n         = st_ff.ce_n;
  assign token_latch_select_n = st_ff.sem_n;
  assign read_write_n         = st_ff.rw_n;
  assign output_enable_n      = st_ff.oe_n;
  assign mem_addr             = st_ff.addr;
  assign data_out             = st_ff.wdata;
  assign data_oe              = st_ff.data_oe;

  // ------------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------------
  logic [7:0] wr_lo_cnt;
  logic [7:0] oe_lo_cnt;
  logic [7:0] gap_cnt;
  logic       tok_wr_seen;

  // Saturating run lengths of the strobes, for the timing checks only
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_lo_cnt   <= '0;
      oe_lo_cnt   <= '0;
      gap_cnt     <= '0;
      tok_wr_seen <= 1'b0;
    end else if (clk_en) begin
      wr_lo_cnt <= (st_ff.rw_n || !st_ff.data_oe) ? 8'h00 : wr_lo_cnt + {7'h00, wr_lo_cnt != 8'hff};
      oe_lo_cnt <= st_ff.oe_n ? 8'h00 : oe_lo_cnt + {7'h00, oe_lo_cnt != 8'hff};
      gap_cnt   <= !st_ff.sem_n ? 8'h00 : gap_cnt + {7'h00, gap_cnt != 8'hff};
      if (!st_ff.sem_n) begin
        tok_wr_seen <= !st_ff.rw_n || (tok_wr_seen && st_ff.oe_n);
      end
    end
  end

  a_write_setup: assert property (@(posedge clk) disable iff (srst)
    $rose(st_ff.rw_n) |-> st_ff.data_oe && (wr_lo_cnt >= 8'(WR_CYC)))
    else $error("write ended before data setup or without data driven");

  a_read_flow: assert property (@(posedge clk) disable iff (srst)
    $rose(st_ff.oe_n) && !st_ff.ce_n |-> oe_lo_cnt >= 8'(RD_CYC))
    else $error("memory data sampled before flowthrough delay");

  a_read_select: assert property (@(posedge clk) disable iff (srst)
    !st_ff.oe_n |-> (!st_ff.ce_n || !st_ff.sem_n) && st_ff.rw_n && !st_ff.data_oe)
    else $error("output enable without a select or during a write");

  a_token_select: assert property (@(posedge clk) disable iff (srst)
    !st_ff.sem_n |-> st_ff.ce_n)
    else $error("token select and memory select both low");

  a_busy_hold: assert property (@(posedge clk) disable iff (srst)
    $fell(st_ff.rw_n) && !st_ff.ce_n |-> $past(busy_n) && $past(st_ff.ce_n, SETTLE_CYC) == 1'b0)
    else $error("memory write started before busy settled");

  a_take_poll: assert property (@(posedge clk) disable iff (srst)
    st_ff.rsp_valid && st_ff.op == DPM_OP_SEM_TAKE && st_ff.rdata[`DPM_TOKEN_BIT] |-> st_ff.polls == '0)
    else $error("take returned unowned token before polls ran out");

  a_token_gap: assert property (@(posedge clk) disable iff (srst)
    $fell(st_ff.sem_n) && tok_wr_seen && !st_ff.oe_n |-> gap_cnt >= 8'(GAP_CYC))
    else $error("token read too soon after token write");

endmodule // dpm_host

//--- src/dpm_params.svh
`ifndef DPM_PARAMS_SVH
`define DPM_PARAMS_SVH

// ----------------------------------------------------------------------------
// Clock
// ----------------------------------------------------------------------------
`define DPM_CLK_PERIOD_NS      10

// ----------------------------------------------------------------------------
// Port timing of the dual-port memory, in ns
// ----------------------------------------------------------------------------
`define DPM_SELECT_ACCESS_NS   20
`define DPM_DRIVE_ACCESS_NS    12
`define DPM_WRITE_DATA_SETUP_NS 15
`define DPM_FLOWTHROUGH_NS     30
`define DPM_BUSY_SETTLE_NS     20
`define DPM_TOKEN_OP_GAP_NS    10
`define DPM_TOKEN_WR_RD_NS     10

// ----------------------------------------------------------------------------
// Geometry and token latches
// ----------------------------------------------------------------------------
`define DPM_ADDR_W             12
`define DPM_DATA_W             8
`define DPM_TOKEN_ADDR_W       3
`define DPM_TOKEN_BIT          0
`define DPM_TAKE_POLLS         16
`define DPM_TIMER_W            8

`endif

//--- src/dpm_pkg.sv
package dpm_pkg;

  // --------------------------------------------------------------------------
  // Requests the host accepts on its user side
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    DPM_OP_MEM_RD   = 3'h0,
    DPM_OP_MEM_WR   = 3'h1,
    DPM_OP_SEM_RD   = 3'h2,
    DPM_OP_SEM_WR   = 3'h3,
    DPM_OP_SEM_TAKE = 3'h4
  } dpm_op_type;

  // --------------------------------------------------------------------------
  // Pin sequencer states, one-hot
  // --------------------------------------------------------------------------
  typedef enum logic [4:0] {
    DPM_ST_IDLE = 5'h01,
    DPM_ST_ARB  = 5'h02,
    DPM_ST_ACC  = 5'h04,
    DPM_ST_REL  = 5'h08,
    DPM_ST_GAP  = 5'h10
  } dpm_state_type;

endpackage

//--- src/dpm_tmr.sv
`timescale 1ns/1ps
`include "dpm_params.svh"

// Load N, done is high in the Nth cycle in the loaded state
module dpm_tmr
  import dpm_pkg::*;
#(
  parameter int W = `DPM_TIMER_W
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         clk_en,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic              done
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } dpm_tmr_state_type;

  dpm_tmr_state_type tmr_ff;
  dpm_tmr_state_type nxt_tmr;

  // ------------------------------------------------------------------------
  // Next count
  // ------------------------------------------------------------------------
  always_comb begin
    nxt_tmr = tmr_ff;
    if (load) begin
      nxt_tmr.cnt = load_val - W'(1);
    end else if (tmr_ff.cnt != '0) begin
      nxt_tmr.cnt = tmr_ff.cnt - W'(1);
    end
  end

  // Frozen with the rest of the host while clk_en is low
  always_ff @(posedge clk) begin
    if (srst) begin
      tmr_ff <= '0;
    end else if (clk_en) begin
      tmr_ff <= nxt_tmr;
    end
  end

  assign done = (tmr_ff.cnt == '0);

endmodule // dpm_tmr

//--- testbench/dpm_dev_model.sv
`timescale 1ns/1ps

// --------------------
// One port of the shared memory, seen from the host; the peer is driven by tasks
// --------------------
module dpm_dev_model
  import dpm_pkg::*;
#(
  parameter int AW = 12,
  parameter int DW = 8
) (
  input  wire logic          clk,
  input  wire logic          mem_select_n,
  input  wire logic          token_latch_select_n,
  input  wire logic          read_write_n,
  input  wire logic          output_enable_n,
  input  wire logic [AW-1:0] mem_addr,
  input  wire logic [DW-1:0] data_out,
  input  wire logic          data_oe,
  output logic [DW-1:0]      data_in,
  output logic               busy_n,
  output logic               int_n
);
  localparam logic [AW-1:0] BOX_MINE = {{(AW-1){1'b1}}, 1'b0};
  localparam logic [AW-1:0] BOX_PEER = {AW{1'b1}};
  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic [7:0]    tok_mine, tok_peer, tok_wait;
  logic          own_int, peer_int, peer_on, wr_q, tok_q, bsy_q, tok_val, wr_now, rd_now;
  logic          role_master, master_busy_n;
  logic [AW-1:0] peer_addr, wa_q;
  logic [DW-1:0] wd_q, last_q;
  int            oe_cnt, rd_lag;

  // Strobes; a released bus shows the inverse of its last value, never a held copy
  assign wr_now = !read_write_n && data_oe && !(mem_select_n && token_latch_select_n);
  assign rd_now = read_write_n && !output_enable_n && !(mem_select_n && token_latch_select_n);
  // Master role drives the match result; slave role passes on the master's busy
  assign busy_n = role_master ? !(peer_on && !mem_select_n && mem_addr == peer_addr) :
                  master_busy_n;
  assign int_n  = !own_int;
  assign data_in = (rd_now && oe_cnt >= rd_lag) ?
                   (!token_latch_select_n ? {DW{tok_val}} : mem[mem_addr]) : ~last_q;

  initial begin
    for (int i = 0; i < (1<<AW); i++) mem[i] = '0;
    {tok_mine, tok_peer, tok_wait} = '0;
    {own_int, peer_int, peer_on, wr_q, tok_q, bsy_q, tok_val} = '0;
    role_master = 1'b1;
    master_busy_n = 1'b1;
    {peer_addr, wa_q, wd_q, last_q} = '0;
    oe_cnt = 0;
    rd_lag = 0;
  end

  // Write commits when it ends; token value latched as the read starts
  always @(posedge clk) begin
    oe_cnt <= rd_now ? oe_cnt + 1 : 0;
    if (rd_now && oe_cnt == 0) tok_val <= !tok_mine[mem_addr[2:0]];
    if (rd_now) last_q <= data_in;
    wr_q <= wr_now;
    if (wr_now) begin
      wa_q <= mem_addr;
      wd_q <= data_out;
      tok_q <= !token_latch_select_n;
      bsy_q <= !busy_n;
    end
    if (wr_q && !wr_now) begin
      if (tok_q && !wd_q[0]) begin
        if (tok_peer[wa_q[2:0]]) tok_wait[wa_q[2:0]] <= 1'b1;
        else tok_mine[wa_q[2:0]] <= 1'b1;
      end else if (tok_q) begin
        tok_mine[wa_q[2:0]] <= 1'b0;
        tok_wait[wa_q[2:0]] <= 1'b0;
      end else begin
        mem[wa_q] <= wd_q;
        if (wa_q == BOX_PEER && !bsy_q) peer_int <= 1'b1;
      end
    end
    // Reading the peer box leaves peer_int alone
    if (rd_now && !mem_select_n && mem_addr == BOX_MINE && busy_n) own_int <= 1'b0;
  end

  task automatic peer_mail(input logic [DW-1:0] d);
    mem[BOX_MINE] = d;
    own_int = 1'b1;
  endtask
  task automatic peer_grab(input int i);
    tok_peer[i] = 1'b1;
  endtask
  task automatic peer_free(input int i);
    tok_peer[i] = 1'b0;
    if (tok_wait[i]) tok_mine[i] = 1'b1;
    tok_wait[i] = 1'b0;
  endtask
endmodule // dpm_dev_model

//--- testbench/dpm_host_tb.sv
`timescale 1ns/1ps

module dpm_host_tb;
  import dpm_pkg::*;
  logic        clk, srst, clk_en, req_valid, req_ready, rsp_valid, rsp_busy, mailbox_pending;
  logic        mem_select_n, token_latch_select_n, read_write_n, output_enable_n, data_oe, busy_n, int_n;
  dpm_op_type  req_op;
  logic [11:0] req_addr, mem_addr, a;
  logic [7:0]  req_wdata, rsp_rdata, data_out, data_in, d;
  int          err_total, n_compared, cycles, seed, lat;

  dpm_host #(.POLLS(2)) dut (.clk(clk), .srst(srst), .clk_en(clk_en), .req_valid(req_valid),
    .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_busy(rsp_busy), .mailbox_pending(mailbox_pending),
    .mem_select_n(mem_select_n), .token_latch_select_n(token_latch_select_n), .read_write_n(read_write_n),
    .output_enable_n(output_enable_n), .mem_addr(mem_addr), .data_out(data_out), .data_oe(data_oe),
    .data_in(data_in), .busy_n(busy_n), .int_n(int_n));
  dpm_dev_model dm (.clk(clk), .mem_select_n(mem_select_n), .token_latch_select_n(token_latch_select_n),
    .read_write_n(read_write_n), .output_enable_n(output_enable_n), .mem_addr(mem_addr),
    .data_out(data_out), .data_oe(data_oe), .data_in(data_in), .busy_n(busy_n), .int_n(int_n));

  // --------------------
  // Checks and transfers
  // --------------------
  task automatic chk_data(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_flag(input string nm, input logic e, input logic g);
    chk_data(nm, {7'h00, e}, {7'h00, g});
  endtask
  task automatic chk_count(input string nm, input int e, input int g);
    n_compared++;
    if (g != e) begin
      err_total++;
      $display("FAIL %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  // Ends at the negedge of the answer cycle, where the outputs have settled
  task automatic run_op(input dpm_op_type op, input logic [11:0] ad, input logic [7:0] wd);
    @(posedge clk);
    req_valid <= 1'b1;
    req_op <= op;
    req_addr <= ad;
    req_wdata <= wd;
    @(negedge clk);
    while (req_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    req_valid <= 1'b0;
    lat = 0;
    do begin
      @(negedge clk);
      lat++;
    end while (rsp_valid !== 1'b1 && lat < 300);
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Hang guard well above the few hundred cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      print_verdict();
    end
  end

  initial begin
    {err_total, n_compared, cycles, lat} = '0;
    seed = 31;
    srst = 1'b1;
    clk_en = 1'b1;
    req_valid = 1'b0;
    req_op = DPM_OP_MEM_RD;
    req_addr = 12'h000;
    req_wdata = 8'h00;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    chk_flag("ready", 1'b1, req_ready);
    chk_flag("sel", 1'b1, mem_select_n);
    chk_flag("drive", 1'b0, data_oe);
    // Random write then read back, slow device answers among them
    for (int i = 0; i < 12; i++) begin
      a = (i == 0) ? 12'h000 : (i == 1) ? 12'hffd : 12'($random(seed));
      d = 8'($random(seed));
      dm.rd_lag = (i < 2) ? 2 : $unsigned($random(seed)) % 3;
      run_op(DPM_OP_MEM_WR, a, d);
      chk_count("wr_lat", 6, lat);
      run_op(DPM_OP_MEM_RD, a, 8'h00);
      chk_count("rd_lat", 7, lat);
      chk_data("rd_data", d, rsp_rdata);
    end
    // Freeze in mid-read: all state holds, so the answer comes three cycles late
    fork
      run_op(DPM_OP_MEM_RD, a, 8'h00);
      begin
        repeat (4) @(posedge clk);
        clk_en <= 1'b0;
        repeat (3) @(posedge clk);
        clk_en <= 1'b1;
      end
    join
    chk_count("frozen_lat", 10, lat);
    chk_data("frozen_data", d, rsp_rdata);
    // Slave role: the master holds busy low, so the write waits until it settles high
    dm.role_master = 1'b0;
    dm.master_busy_n = 1'b0;
    fork
      run_op(DPM_OP_MEM_WR, 12'h2a5, 8'h96);
      begin
        repeat (6) @(negedge clk);
        chk_flag("wr_held", 1'b1, read_write_n);
        dm.master_busy_n = 1'b1;
      end
    join
    dm.role_master = 1'b1;
    chk_flag("wr_busy", 1'b1, rsp_busy);
    chk_count("held_lat", 9, lat);
    run_op(DPM_OP_MEM_RD, 12'h2a5, 8'h00);
    chk_data("wr_late", 8'h96, rsp_rdata);
    dm.rd_lag = 1;
    // Peer holds another address: no busy, no delay
    dm.peer_addr = 12'h123;
    dm.peer_on = 1'b1;
    run_op(DPM_OP_MEM_RD, 12'h124, 8'h00);
    chk_flag("no_busy", 1'b0, rsp_busy);
    chk_count("free_lat", 7, lat);
    // Mailboxes
    dm.peer_mail(8'hc3);
    repeat (2) @(negedge clk);
    chk_flag("pending", 1'b1, mailbox_pending);
    run_op(DPM_OP_MEM_RD, 12'hfff, 8'h00);
    repeat (2) @(negedge clk);
    chk_flag("pending", 1'b1, mailbox_pending);
    run_op(DPM_OP_MEM_WR, 12'hfff, 8'h5a);
    chk_flag("peer_int", 1'b1, dm.peer_int);
    dm.peer_addr = 12'hffe;
    fork
      run_op(DPM_OP_MEM_RD, 12'hffe, 8'h00);
      begin
        repeat (9) @(negedge clk);
        chk_flag("held", 1'b1, mailbox_pending);
        dm.peer_on = 1'b0;
      end
    join
    chk_flag("busy_seen", 1'b1, rsp_busy);
    chk_flag("long_lat", 1'b1, lat > 9);
    chk_data("box", 8'hc3, rsp_rdata);
    repeat (2) @(negedge clk);
    chk_flag("cleared", 1'b0, mailbox_pending);
    // Token latches: take, read through other upper bits, release
    for (int i = 0; i < 8; i++) begin
      a = 12'($random(seed));
      run_op(DPM_OP_SEM_TAKE, {a[11:3], 3'(i)}, 8'hff);
      chk_data("take", 8'h00, rsp_rdata);
      run_op(DPM_OP_SEM_RD, {~a[11:3], 3'(i)}, 8'h00);
      chk_count("srd_lat", 4, lat);
      chk_data("own", 8'h00, rsp_rdata);
      run_op(DPM_OP_SEM_WR, {a[11:3], 3'(i)}, 8'h01);
      run_op(DPM_OP_SEM_RD, 12'(i), 8'h00);
      chk_data("freed", 8'hff, rsp_rdata);
    end
    dm.peer_grab(5);
    run_op(DPM_OP_SEM_TAKE, 12'h005, 8'h00);
    chk_data("refused", 8'hff, rsp_rdata);
    dm.peer_free(5);
    run_op(DPM_OP_SEM_RD, 12'h005, 8'h00);
    chk_data("handed", 8'h00, rsp_rdata);
    print_verdict();
  end
endmodule // dpm_host_tb
